// ### rtl/flash_spm_consts.svh
// constants for the self-programming control and protection block
`ifndef FLASH_SPM_CONSTS_SVH
`define FLASH_SPM_CONSTS_SVH
`define SPM_CSR_ADDR       12'h000
`define SPM_LOCK_ADDR      12'h004
`define SPM_CMD_ADDR       12'h008
`define SPM_STAT_ADDR      12'h00C
`define SPM_FLASH_ADDR     12'h010
`define SPM_FUSE_ADDR      12'h014
`define SPM_CSR_RESET      8'h00
`define SPM_LOCK_RESET     8'hFF
`define SPM_WINDOW_CYC     3'h4
`define SPM_LPM_WINDOW_CYC 3'h3
`define SPM_BIT_IE         7
`define SPM_BIT_BUSY       6
`define SPM_BIT_RES        5
`define SPM_BIT_REEN       4
`define SPM_BIT_LOCKSET    3
`define SPM_BIT_PGWR       2
`define SPM_BIT_PGER       1
`define SPM_BIT_EN         0
`define SPM_PAT_REEN       5'h11
`define SPM_PAT_LOCKSET    5'h09
`define SPM_PAT_PGWR       5'h05
`define SPM_PAT_PGER       5'h03
`define SPM_PAT_LOAD       5'h01
`define SPM_CMD_STORE      2'h1
`define SPM_CMD_LOAD       2'h2
`define SPM_RESET_APP_ADDR 16'h0000
`endif

// ### rtl/flash_spm_pkg.sv
// types for the self-programming control and protection block
package flash_spm_pkg;
    typedef enum logic [2:0] {
        ACT_NONE    = 3'b000,
        ACT_LOAD    = 3'b001,
        ACT_ERASE   = 3'b010,
        ACT_WRITE   = 3'b011,
        ACT_LOCKSET = 3'b100,
        ACT_REEN    = 3'b101
    } spm_action_t;
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_ARMED = 2'b01,
        ST_BUSY  = 2'b10
    } spm_state_t;
endpackage

// ### rtl/flash_self_program_protection.sv
// self-programming control, boot lock protection and lock/fuse readback
//
// Register access over AHB-Lite and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "flash_spm_consts.svh"

module flash_self_program_protection #(
    parameter int                 ADDR_W          = 16,
    parameter logic [ADDR_W-1:0] BOOT_START      = 16'h1C00,
    parameter logic [ADDR_W-1:0] RWW_LIMIT       = 16'h1C00
) (
    input  wire logic                hclk,
    input  wire logic                hresetn,
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [31:0]         hwdata,
    input  wire logic                hready,
    output logic      [31:0]         hrdata,
    output logic                     hreadyout,
    output logic                     hresp,
    input  wire logic                global_irq_flag,
    input  wire logic                vectors_in_boot,
    input  wire logic                exec_in_boot,
    input  wire logic [7:0]          fuse_low,
    input  wire logic [7:0]          fuse_high,
    input  wire logic                boot_reset_fuse,
    input  wire logic                flash_done,
    output logic                     ready_irq,
    output logic                     irq_suppress,
    output logic                     rww_blocked,
    output logic                     buffer_discard,
    output logic                     flash_start,
    output logic      [2:0]          flash_action,
    output logic      [ADDR_W-1:0]   flash_addr,
    output logic      [15:0]         flash_data,
    output logic      [ADDR_W-1:0]   reset_vector,
    output logic      [7:0]          lock_bits
);
    import flash_spm_pkg::*;

    // address phase capture
    logic              wr_pend_q;
    logic              rd_pend_q;
    logic [11:0]       addr_q;
    logic [7:0]        csr_q;
    logic [7:0]        lock_q;
    logic [2:0]        win_q;
    logic [2:0]        lpm_win_q;
    spm_state_t        state_q;
    spm_action_t       act_q;
    logic              loading_q;
    logic [7:0]        lpm_result_q;
    logic              fuse_sel_q;

    wire logic addr_ph = hsel && hready && htrans[1];
    wire logic csr_wr  = wr_pend_q && (addr_q == `SPM_CSR_ADDR);
    wire logic cmd_wr  = wr_pend_q && (addr_q == `SPM_CMD_ADDR);
    wire logic [4:0]  pat = hwdata[4:0];
    wire logic [1:0]  cmd = hwdata[31:30];
    wire logic [ADDR_W-1:0] z = hwdata[ADDR_W+15:16];

    // classify an address into boot (1) or application (0) section
    function automatic logic in_boot(input logic [ADDR_W-1:0] a);
        in_boot = (a >= BOOT_START);
    endfunction

    // decode a written pattern into an action
    function automatic spm_action_t decode(input logic [4:0] p);
        case (p)
            `SPM_PAT_REEN:    decode = ACT_REEN;
            `SPM_PAT_LOCKSET: decode = ACT_LOCKSET;
            `SPM_PAT_PGWR:    decode = ACT_WRITE;
            `SPM_PAT_PGER:    decode = ACT_ERASE;
            `SPM_PAT_LOAD:    decode = ACT_LOAD;
            default:          decode = ACT_NONE;
        endcase
    endfunction

    wire spm_action_t new_act = decode(pat);
    wire logic store_op = cmd_wr && (cmd == `SPM_CMD_STORE);
    wire logic load_op  = cmd_wr && (cmd == `SPM_CMD_LOAD);
    // app field in lock bits [3:2], boot field in [5:4]
    wire logic [1:0] app_f  = lock_q[3:2];
    wire logic [1:0] boot_f = lock_q[5:4];
    wire logic tgt_boot = in_boot(z);
    wire logic app_wr_blk  = !app_f[0];
    wire logic boot_wr_blk = !boot_f[0];
    wire logic store_blk = tgt_boot ? boot_wr_blk : app_wr_blk;
    wire logic store_ok = store_op && exec_in_boot && (state_q == ST_ARMED);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q    <= 12'h000;
        end else begin
            wr_pend_q <= addr_ph && hwrite;
            rd_pend_q <= addr_ph && !hwrite;
            addr_q    <= haddr[11:0];
        end
    end

    // control/status register and action sequencing
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            csr_q     <= `SPM_CSR_RESET;
            state_q   <= ST_IDLE;
            act_q     <= ACT_NONE;
            win_q     <= 3'h0;
            lpm_win_q <= 3'h0;
            loading_q <= 1'b0;
            flash_start    <= 1'b0;
            flash_action   <= 3'h0;
            flash_addr     <= '0;
            flash_data     <= 16'h0000;
            buffer_discard <= 1'b0;
        end else begin
            flash_start    <= 1'b0;
            buffer_discard <= 1'b0;
            if (lpm_win_q != 3'h0) begin
                lpm_win_q <= lpm_win_q - 3'h1;
            end
            case (state_q)
                ST_IDLE, ST_ARMED: begin
                    if (state_q == ST_ARMED) begin
                        if (win_q == 3'h1) begin
                            state_q <= ST_IDLE;
                            act_q   <= ACT_NONE;
                            csr_q[4:0] <= 5'h00;
                        end
                        win_q <= win_q - 3'h1;
                    end
                    if (store_ok) begin
                        state_q <= ST_IDLE;
                        act_q   <= ACT_NONE;
                        csr_q[4:0] <= 5'h00;
                        // the target section's lock field gates erase and write; loads are not gated
                        case (act_q)
                            ACT_LOAD: begin
                                loading_q <= 1'b1;
                                flash_start  <= 1'b1;
                                flash_action <= ACT_LOAD;
                                flash_addr   <= z;
                                flash_data   <= hwdata[15:0];
                                csr_q[`SPM_BIT_BUSY] <= 1'b0;
                            end
                            ACT_ERASE, ACT_WRITE: begin
                                if (!store_blk) begin
                                    flash_start  <= 1'b1;
                                    flash_action <= act_q;
                                    flash_addr   <= z;
                                    state_q      <= ST_BUSY;
                                    csr_q[`SPM_BIT_EN] <= 1'b1;
                                    if (act_q == ACT_WRITE) begin
                                        loading_q <= 1'b0;
                                    end
                                    if (z < RWW_LIMIT) begin
                                        csr_q[`SPM_BIT_BUSY] <= 1'b1;
                                    end
                                end
                            end
                            ACT_REEN: begin
                                csr_q[`SPM_BIT_BUSY] <= 1'b0;
                            end
                            default: begin
                            end
                        endcase
                    end else if (csr_wr) begin
                        csr_q[`SPM_BIT_IE] <= hwdata[`SPM_BIT_IE];
                        if (new_act != ACT_NONE) begin
                            state_q    <= ST_ARMED;
                            act_q      <= new_act;
                            win_q      <= `SPM_WINDOW_CYC;
                            csr_q[4:0] <= pat;
                            if (new_act == ACT_LOCKSET) begin
                                lpm_win_q <= `SPM_LPM_WINDOW_CYC;
                            end
                            if (new_act == ACT_REEN && loading_q) begin
                                loading_q      <= 1'b0;
                                buffer_discard <= 1'b1;
                            end
                        end
                    end
                end
                ST_BUSY: begin
                    if (csr_wr) begin
                        csr_q[`SPM_BIT_IE] <= hwdata[`SPM_BIT_IE];
                    end
                    if (flash_done) begin
                        state_q    <= ST_IDLE;
                        act_q      <= ACT_NONE;
                        csr_q[4:0] <= 5'h00;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // lock bits only programmed, from low data
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lock_q <= `SPM_LOCK_RESET;
        end else if (store_ok && act_q == ACT_LOCKSET) begin
            lock_q <= lock_q & hwdata[7:0];
        end
    end

    // lock or fuse readback by address bit 0
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lpm_result_q <= 8'h00;
            fuse_sel_q   <= 1'b0;
        end else if (load_op) begin
            fuse_sel_q <= z[0];
            if (lpm_win_q != 3'h0 && act_q == ACT_LOCKSET) begin
                lpm_result_q <= z[0] ? fuse_low : lock_q;
            end else if (z[0]) begin
                lpm_result_q <= fuse_high;
            end else begin
                lpm_result_q <= fuse_low;
            end
        end
    end

    // status outputs, all registered
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ready_irq    <= 1'b0;
            irq_suppress <= 1'b0;
            rww_blocked  <= 1'b0;
            reset_vector <= '0;
            lock_bits    <= `SPM_LOCK_RESET;
        end else begin
            ready_irq <= csr_q[`SPM_BIT_IE] && global_irq_flag && !csr_q[`SPM_BIT_EN];
            irq_suppress <= (vectors_in_boot && !exec_in_boot && (app_f != 2'b11) && (app_f != 2'b10))
                         || (!vectors_in_boot && exec_in_boot && (boot_f != 2'b11) && (boot_f != 2'b10));
            rww_blocked <= csr_q[`SPM_BIT_BUSY];
            reset_vector <= boot_reset_fuse ? `SPM_RESET_APP_ADDR : BOOT_START;
            lock_bits    <= lock_q;
        end
    end

    // read mux; unmapped reads as zero, always OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (addr_ph && !hwrite) begin
                case (haddr[11:0])
                    `SPM_CSR_ADDR:   hrdata <= {24'h0, csr_q & 8'hDF};
                    `SPM_LOCK_ADDR:  hrdata <= {24'h0, lock_q};
                    `SPM_STAT_ADDR:  hrdata <= {24'h0, lpm_result_q};
                    `SPM_FUSE_ADDR:  hrdata <= {16'h0, fuse_high, fuse_low};
                    `SPM_FLASH_ADDR: hrdata <= {29'h0, fuse_sel_q, loading_q, state_q == ST_BUSY};
                    default:         hrdata <= 32'h0000_0000;
                endcase
            end
        end
    end

endmodule
`default_nettype wire

// ### tb/flash_spm_props.sv
// assertion checker for the self-programming control block
`timescale 1ns/1ns
`default_nettype none
`include "flash_spm_consts.svh"
module flash_spm_props #(
    parameter int                ADDR_W     = 16,
    parameter logic [ADDR_W-1:0] BOOT_START = 16'h1C00
) (
    input wire logic              hclk,
    input wire logic              hresetn,
    input wire logic              hsel,
    input wire logic [31:0]       haddr,
    input wire logic [1:0]        htrans,
    input wire logic              hwrite,
    input wire logic              hready,
    input wire logic [31:0]       hrdata,
    input wire logic              global_irq_flag,
    input wire logic              vectors_in_boot,
    input wire logic              exec_in_boot,
    input wire logic              boot_reset_fuse,
    input wire logic              ready_irq,
    input wire logic              irq_suppress,
    input wire logic              buffer_discard,
    input wire logic              flash_start,
    input wire logic [ADDR_W-1:0] reset_vector,
    input wire logic [7:0]        lock_bits
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // high bit of a lock field programmed means loads are fenced, so vectors there are unsafe
    wire sup_w = (vectors_in_boot & ~exec_in_boot & ~lock_bits[3]) | (~vectors_in_boot & exec_in_boot & ~lock_bits[5]);
    wire rd_w  = hsel & hready & htrans[1] & ~hwrite;

    vector_sel_a: assert property (
        $past(hresetn) |-> reset_vector == ($past(boot_reset_fuse) ? `SPM_RESET_APP_ADDR : BOOT_START))
        else $error("reset vector does not follow the fuse");
    irq_ready_a: assert property (
        ready_irq |-> $past(global_irq_flag))
        else $error("ready request without global flag");
    irq_mask_a: assert property (
        $past(hresetn) && $past(hresetn, 2) && sup_w == $past(sup_w) && sup_w == $past(sup_w, 2)
        |-> irq_suppress == sup_w)
        else $error("interrupt suppression wrong for lock field");
    start_pulse_a: assert property (
        flash_start |=> !flash_start)
        else $error("flash start longer than one cycle");
    start_boot_a: assert property (
        flash_start |-> $past(exec_in_boot))
        else $error("store started from application section");
    discard_pulse_a: assert property (
        buffer_discard |=> !buffer_discard)
        else $error("discard longer than one cycle");
    lock_program_a: assert property (
        $past(hresetn) |-> (lock_bits & ~$past(lock_bits)) == 8'h00)
        else $error("lock bit returned to unprogrammed");
    csr_reserved_a: assert property (
        rd_w && haddr[11:0] == `SPM_CSR_ADDR |=> hrdata[`SPM_BIT_RES] == 1'b0)
        else $error("reserved control bit reads one");

    cover property (flash_start ##1 !flash_start);
    cover property (buffer_discard);
    cover property ($rose(irq_suppress));
    cover property ($rose(ready_irq));
endmodule

bind flash_self_program_protection flash_spm_props #(.ADDR_W(ADDR_W), .BOOT_START(BOOT_START)) props_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hrdata(hrdata), .global_irq_flag(global_irq_flag), .vectors_in_boot(vectors_in_boot),
    .exec_in_boot(exec_in_boot), .boot_reset_fuse(boot_reset_fuse), .ready_irq(ready_irq),
    .irq_suppress(irq_suppress), .buffer_discard(buffer_discard), .flash_start(flash_start),
    .reset_vector(reset_vector), .lock_bits(lock_bits));
`default_nettype wire

// ### tb/flash_array_model.sv
// flash array model answering erase and write starts with a done pulse
`timescale 1ns/1ns
`default_nettype none
module flash_array_model (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       slow,
    input  wire logic       flash_start,
    input  wire logic [2:0] flash_action,
    output logic            flash_done
);
    int left_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            left_q <= 0;
            flash_done <= 1'b0;
        end else begin
            flash_done <= (left_q == 1);
            // array stays busy long enough for a re-enable to land mid-operation
            if (flash_start && (flash_action == 3'h2 || flash_action == 3'h3)) begin
                left_q <= slow ? 40 : 3;
            end else if (left_q != 0) begin
                left_q <= left_q - 1;
            end
        end
    end
endmodule
`default_nettype wire

// ### tb/tb.sv
// self-checking bench for the self-programming control block
`timescale 1ns/1ns
`default_nettype none
module tb;
    localparam logic [15:0] BOOT = 16'h6000;
    localparam logic [31:0] SAPP = 32'h4100_1234;
    logic        hclk, hresetn, hsel, hwrite, global_irq_flag, vectors_in_boot, exec_in_boot, boot_reset_fuse, slow;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize, flash_action, last_act;
    logic [7:0]  fuse_low, lock_bits;
    logic [15:0] flash_addr, flash_data, reset_vector, last_addr, last_data;
    logic        hreadyout, hresp, flash_done, ready_irq, irq_suppress, rww_blocked, buffer_discard, flash_start;
    int          bad_count, comparisons, n, d, k;
    int          starts = 0;
    int          discards = 0;
    logic [7:0]  row_d [4] = '{8'hFF, 8'hF7, 8'hDF, 8'h00};
    logic [7:0]  row_e [4] = '{8'hFF, 8'hF7, 8'hD7, 8'h00};

    // boot start and rww limit raised so that store addresses (command bits on top) reach both sections
    flash_self_program_protection #(.ADDR_W(16), .BOOT_START(BOOT), .RWW_LIMIT(BOOT)) DUT (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .global_irq_flag(global_irq_flag), .vectors_in_boot(vectors_in_boot),
        .exec_in_boot(exec_in_boot), .fuse_low(fuse_low), .fuse_high(8'hA5), .boot_reset_fuse(boot_reset_fuse),
        .flash_done(flash_done), .ready_irq(ready_irq), .irq_suppress(irq_suppress), .rww_blocked(rww_blocked),
        .buffer_discard(buffer_discard), .flash_start(flash_start), .flash_action(flash_action),
        .flash_addr(flash_addr), .flash_data(flash_data), .reset_vector(reset_vector), .lock_bits(lock_bits));
    flash_array_model array_i (.hclk(hclk), .hresetn(hresetn), .slow(slow), .flash_start(flash_start),
        .flash_action(flash_action), .flash_done(flash_done));

    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        if (flash_start === 1'b1) begin
            starts <= starts + 1;
            last_act <= flash_action;
            last_addr <= flash_addr;
            last_data <= flash_data;
        end
        if (buffer_discard === 1'b1) begin
            discards <= discards + 1;
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR time %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int c);
        repeat (c) @(posedge hclk);
    endtask
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {20'h00000, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    // pattern write followed by a command inside the four-clock window
    task automatic act(input logic [7:0] pat, input logic [31:0] cmd);
        bus(1'b1, 12'h000, {24'h000000, pat});
        bus(1'b1, 12'h008, cmd);
    endtask
    task automatic wait_done;
        for (k = 0; k < 80 && flash_done !== 1'b1; k++) tick(1);
        // a done pulse that never comes is a failure, not a silent pass
        if (k == 80) begin
            bad_count++;
        end
    endtask
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        #(5000 * 4);
        bad_count++;
        test_done;
    end

    initial begin
        {hresetn, hsel, hwrite, global_irq_flag, vectors_in_boot, slow} = '0;
        {exec_in_boot, boot_reset_fuse} = 2'b11;
        {haddr, hwdata, htrans} = '0;
        hsize = 3'h2;
        fuse_low = 8'h5A;
        tick(12);
        hresetn <= 1'b1;
        tick(1);
        for (int i = 0; i < 4; i++) begin
            act(8'h09, {16'h4000, 8'h00, row_d[i]});
            tick(2);
            check(lock_bits, row_e[i]);
            bus(1'b0, 12'h004, 32'h0);
            check(rd, {24'h000000, row_e[i]});
            tick(6);
            bus(1'b0, 12'h000, 32'h0);
            check(rd, 32'h0);
        end
        n = starts;
        act(8'h03, SAPP);
        act(8'h03, 32'h7000_0000);
        tick(3);
        check(starts, n);
        vectors_in_boot <= 1'b1;
        exec_in_boot <= 1'b0;
        tick(4);
        check(irq_suppress, 1'b1);
        vectors_in_boot <= 1'b0;
        exec_in_boot <= 1'b1;
        tick(4);
        check(irq_suppress, 1'b1);
        vectors_in_boot <= 1'b1;
        tick(4);
        check(irq_suppress, 1'b0);
        hresetn <= 1'b0;
        tick(3);
        hresetn <= 1'b1;
        tick(1);
        bus(1'b0, 12'h000, 32'h0);
        check(rd, 32'h0);
        check(hresp, 1'b0);
        check(reset_vector, 16'h0000);
        boot_reset_fuse <= 1'b0;
        tick(3);
        check(reset_vector, BOOT);
        n = starts;
        act(8'h27, SAPP);
        tick(3);
        check(starts, n);
        bus(1'b0, 12'h000, 32'h0);
        check(rd[5], 1'b0);
        bus(1'b1, 12'h000, 32'h01);
        tick(6);
        bus(1'b1, 12'h008, SAPP);
        tick(3);
        check(starts, n);
        exec_in_boot <= 1'b0;
        act(8'h01, SAPP);
        tick(3);
        check(starts, n);
        exec_in_boot <= 1'b1;
        act(8'h01, SAPP);
        tick(3);
        check(starts, n + 1);
        check({last_addr, last_data}, SAPP);
        check(last_act, 3'h1);
        d = discards;
        act(8'h11, SAPP);
        tick(3);
        check(discards, d + 1);
        slow <= 1'b1;
        act(8'h03, SAPP);
        tick(3);
        check(last_act, 3'h2);
        check(rww_blocked, 1'b1);
        bus(1'b0, 12'h010, 32'h0);
        check(rd[0], 1'b1);
        act(8'h11, SAPP);
        tick(3);
        check(rww_blocked, 1'b1);
        wait_done;
        tick(3);
        check(rww_blocked, 1'b1);
        act(8'h11, SAPP);
        tick(3);
        check(rww_blocked, 1'b0);
        slow <= 1'b0;
        act(8'h03, SAPP);
        wait_done;
        tick(3);
        act(8'h01, SAPP);
        tick(3);
        check(rww_blocked, 1'b0);
        act(8'h09, 32'h8000_0000);
        bus(1'b0, 12'h00C, 32'h0);
        check(rd[7:0], 8'hFF);
        act(8'h09, 32'h8001_0000);
        bus(1'b0, 12'h00C, 32'h0);
        check(rd[7:0], 8'h5A);
        global_irq_flag <= 1'b1;
        bus(1'b1, 12'h000, 32'h81);
        tick(2);
        check(ready_irq, 1'b0);
        tick(8);
        check(ready_irq, 1'b1);
        global_irq_flag <= 1'b0;
        tick(3);
        check(ready_irq, 1'b0);
        test_done;
    end
endmodule
`default_nettype wire
